// >>> inc/flic_pkg.sv
// package: constants and types for the four level interrupt controller
package flic_pkg;

  localparam int NUM_SRC = 13;
  localparam int SRC_W   = 4;
  localparam int LVL_W   = 2;
  localparam int VEC_W   = 8;
  localparam int DEPTH   = 5;  // idle plus four levels
  localparam int CLK_MHZ = 25;
  localparam int CLK_PER_MC = 6;
  localparam int MC_W    = 3;
  localparam logic [MC_W-1:0] MC_LAST = MC_W'(CLK_PER_MC - 1);
  localparam logic [LVL_W-1:0] LVL_TOP = 2'h3;

  // source index is the arbitration rank minus one
  localparam logic [SRC_W-1:0] SRC_EXT0  = 4'h0;
  localparam logic [SRC_W-1:0] SRC_BROWN = 4'h1;
  localparam logic [SRC_W-1:0] SRC_WDOG  = 4'h2;
  localparam logic [SRC_W-1:0] SRC_TMR0  = 4'h3;
  localparam logic [SRC_W-1:0] SRC_TWIRE = 4'h4;
  localparam logic [SRC_W-1:0] SRC_CONV  = 4'h5;
  localparam logic [SRC_W-1:0] SRC_EXT1  = 4'h6;
  localparam logic [SRC_W-1:0] SRC_KEY   = 4'h7;
  localparam logic [SRC_W-1:0] SRC_CMP1  = 4'h8;
  localparam logic [SRC_W-1:0] SRC_TMR1  = 4'h9;
  localparam logic [SRC_W-1:0] SRC_CMP2  = 4'hA;
  localparam logic [SRC_W-1:0] SRC_SER   = 4'hB;
  localparam logic [SRC_W-1:0] SRC_BTMO  = 4'hC;

  // sources able to leave power down, indexed by rank
  localparam logic [NUM_SRC-1:0] WAKE_MASK = 13'h05E7;

  // register bit positions
  localparam int A_EXT0 = 0;
  localparam int A_TMR0 = 1;
  localparam int A_EXT1 = 2;
  localparam int A_TMR1 = 3;
  localparam int A_SER  = 4;
  localparam int A_BROWN = 5;
  localparam int A_WDOG = 6;
  localparam int A_GLOBAL = 7;
  localparam int B_TWIRE = 0;
  localparam int B_KEY  = 1;
  localparam int B_CMP2 = 2;
  localparam int B_CONV = 4;
  localparam int B_CMP1 = 5;
  localparam int B_BTMO = 7;

  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [1:0]
  {
    FLIC_RUN  = 2'b00,
    FLIC_IDLE = 2'b01,
    FLIC_PDWN = 2'b10
  } flic_pwr_e;

endpackage : flic_pkg

// >>> hw/flic_core.sv
// four level interrupt controller with external pin logic
// How it works
// - thirteen sources are arbitrated over four priority levels.
// - each source has an enable bit in group a or b.
// - global allow bit cleared blocks every source.
// - level is high priority bit over low priority bit, same position.
// - running routine is preempted only by strictly higher level.
// - routine at top level blocks every other source.
// - higher level request wins among simultaneous requests.
// - fixed ranking only breaks ties inside one level.
// - ranking ext0, brownout, watchdog, timer0, two-wire, converter, ext1, etc.
// - each source has its own fixed vector from 0003h to 0073h.
// - only ext0/1, brownout, keyboard, comparators, watchdog, converter wake power down.
// - level mode requests while sampled pin is low.
// - edge mode sets flag on high sample followed by low sample.
// - edge flag clears when core enters its service routine.
// - level pin still low after return raises a fresh request.
// - level mode flag follows sampled pin, needs no clearing.
// - enabled external request wakes core from idle or power down.
`timescale 1ns/1ns
module flic_core
  import flic_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  nrst_in,
  // configuration registers
  input  wire logic [7:0]            irq_enable_group_a_in,
  input  wire logic [7:0]            irq_enable_group_b_in,
  input  wire logic [7:0]            prio_low_group_a_in,
  input  wire logic [7:0]            prio_high_group_a_in,
  input  wire logic [7:0]            prio_low_group_b_in,
  input  wire logic [7:0]            prio_high_group_b_in,
  input  wire logic                  ext0_trigger_select_in,
  input  wire logic                  ext1_trigger_select_in,
  // external pins, active low
  input  wire logic                  ext_irq_pin0_n_in,
  input  wire logic                  ext_irq_pin1_n_in,
  // peripheral request flags
  input  wire logic                  brownout_flag_in,
  input  wire logic                  watchdog_overflow_flag_in,
  input  wire logic                  timer0_overflow_flag_in,
  input  wire logic                  twowire_attention_flag_in,
  input  wire logic                  converter_done_flag_in,
  input  wire logic                  keypad_flag_in,
  input  wire logic                  comparator1_flag_in,
  input  wire logic                  timer1_overflow_flag_in,
  input  wire logic                  comparator2_flag_in,
  input  wire logic                  serial_flag_in,
  input  wire logic                  bus_timeout_flag_in,
  // core handshake
  input  wire logic                  vector_taken_in,
  input  wire logic                  return_in,
  input  wire flic_pkg::flic_pwr_e   power_mode_in,
  output logic                       irq_request_out,
  output logic [VEC_W-1:0]           irq_vector_out,
  output logic [SRC_W-1:0]           irq_source_out,
  output logic [LVL_W-1:0]           active_level_out,
  output logic                       in_service_out,
  output logic                       wake_out,
  // request flags as seen by software
  output logic                       ext0_request_flag_out,
  output logic                       ext1_request_flag_out
);

  typedef struct packed
  {
    logic [MC_W-1:0]              mc_cnt;
    logic [2:0]                   sync0;
    logic [2:0]                   sync1;
    logic                         pin0;
    logic                         pin1;
    logic                         samp0;
    logic                         samp1;
    logic                         flag0;
    logic                         flag1;
    logic [DEPTH-1:0]             active;
    logic                         req;
    logic [SRC_W-1:0]             src;
    logic [LVL_W-1:0]             lvl;
    logic [VEC_W-1:0]             vec;
    logic                         wake;
  } flic_state_s;

  flic_state_s st;
  flic_state_s next_st;

  // vector address for a rank-ordered source index
  function automatic logic [VEC_W-1:0] flic_vector(input logic [SRC_W-1:0] s);
    unique case (s)
      SRC_EXT0:  flic_vector = 8'h03;
      SRC_TMR0:  flic_vector = 8'h0B;
      SRC_EXT1:  flic_vector = 8'h13;
      SRC_TMR1:  flic_vector = 8'h1B;
      SRC_SER:   flic_vector = 8'h23;
      SRC_BROWN: flic_vector = 8'h2B;
      SRC_TWIRE: flic_vector = 8'h33;
      SRC_KEY:   flic_vector = 8'h3B;
      SRC_CMP2:  flic_vector = 8'h43;
      SRC_WDOG:  flic_vector = 8'h53;
      SRC_CONV:  flic_vector = 8'h5B;
      SRC_CMP1:  flic_vector = 8'h63;
      SRC_BTMO:  flic_vector = 8'h73;
      default:   flic_vector = 8'h00;
    endcase
  endfunction : flic_vector

  // current service level is the highest active stack bit
  function automatic logic [LVL_W-1:0] flic_top(input logic [DEPTH-1:0] a);
    flic_top = 2'h0;
    for (int k = 0; k < DEPTH - 1; k++)
    begin
      if (a[k])
      begin
        flic_top = LVL_W'(k);
      end
    end
  endfunction : flic_top

  logic [NUM_SRC-1:0] raw;
  logic [NUM_SRC-1:0] en;
  logic [NUM_SRC-1:0] plo;
  logic [NUM_SRC-1:0] phi;
  logic [LVL_W-1:0]   lvl [NUM_SRC];
  logic [NUM_SRC-1:0] pend;

  // rank order sources into vectors
  always_comb
  begin
    raw = {bus_timeout_flag_in, serial_flag_in, comparator2_flag_in, timer1_overflow_flag_in,
           comparator1_flag_in, keypad_flag_in, st.flag1, converter_done_flag_in,
           twowire_attention_flag_in, timer0_overflow_flag_in, watchdog_overflow_flag_in,
           brownout_flag_in, st.flag0};
    en  = {irq_enable_group_b_in[B_BTMO], irq_enable_group_a_in[A_SER],
           irq_enable_group_b_in[B_CMP2], irq_enable_group_a_in[A_TMR1],
           irq_enable_group_b_in[B_CMP1], irq_enable_group_b_in[B_KEY],
           irq_enable_group_a_in[A_EXT1], irq_enable_group_b_in[B_CONV],
           irq_enable_group_b_in[B_TWIRE], irq_enable_group_a_in[A_TMR0],
           irq_enable_group_a_in[A_WDOG], irq_enable_group_a_in[A_BROWN],
           irq_enable_group_a_in[A_EXT0]};
    plo = {prio_low_group_b_in[B_BTMO], prio_low_group_a_in[A_SER],
           prio_low_group_b_in[B_CMP2], prio_low_group_a_in[A_TMR1],
           prio_low_group_b_in[B_CMP1], prio_low_group_b_in[B_KEY],
           prio_low_group_a_in[A_EXT1], prio_low_group_b_in[B_CONV],
           prio_low_group_b_in[B_TWIRE], prio_low_group_a_in[A_TMR0],
           prio_low_group_a_in[A_WDOG], prio_low_group_a_in[A_BROWN],
           prio_low_group_a_in[A_EXT0]};
    phi = {prio_high_group_b_in[B_BTMO], prio_high_group_a_in[A_SER],
           prio_high_group_b_in[B_CMP2], prio_high_group_a_in[A_TMR1],
           prio_high_group_b_in[B_CMP1], prio_high_group_b_in[B_KEY],
           prio_high_group_a_in[A_EXT1], prio_high_group_b_in[B_CONV],
           prio_high_group_b_in[B_TWIRE], prio_high_group_a_in[A_TMR0],
           prio_high_group_a_in[A_WDOG], prio_high_group_a_in[A_BROWN],
           prio_high_group_a_in[A_EXT0]};
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_src
      assign lvl[gi]  = {phi[gi], plo[gi]};
      assign pend[gi] = raw[gi] & en[gi] & irq_enable_group_a_in[A_GLOBAL];
    end
  endgenerate

  logic               win_any;
  logic [SRC_W-1:0]   win_src;
  logic [LVL_W-1:0]   win_lvl;
  logic [LVL_W-1:0]   cur_lvl;
  logic               may_preempt;
  logic               mc_tick;

  // scan from lowest rank upward; a strictly higher level or equal level at better
  // rank replaces the holder, so level always dominates rank
  always_comb
  begin
    win_any = 1'b0;
    win_src = SRC_EXT0;
    win_lvl = 2'h0;
    for (int k = NUM_SRC - 1; k >= 0; k--)
    begin
      if (pend[k] && (!win_any || lvl[k] >= win_lvl))
      begin
        win_any = 1'b1;
        win_src = SRC_W'(k);
        win_lvl = lvl[k];
      end
    end
  end

  always_comb
  begin
    cur_lvl = flic_top(st.active);
    // nothing active, or a strictly higher level; top level never beats itself
    may_preempt = (st.active[DEPTH-2:0] == '0) || (win_lvl > cur_lvl);
    mc_tick = (st.mc_cnt == MC_LAST);
  end

  always_comb
  begin
    next_st = st;
    next_st.mc_cnt = mc_tick ? '0 : st.mc_cnt + 1'b1;
    next_st.sync0 = {st.sync0[1:0], ext_irq_pin0_n_in};
    next_st.sync1 = {st.sync1[1:0], ext_irq_pin1_n_in};
    // a pin change is accepted once the last two stages agree
    if (st.sync0[2] == st.sync0[1])
    begin
      next_st.pin0 = st.sync0[2];
    end
    if (st.sync1[2] == st.sync1[1])
    begin
      next_st.pin1 = st.sync1[2];
    end

    // pins are looked at once per machine cycle, so pulses shorter than six clocks may pass
    if (mc_tick)
    begin
      next_st.samp0 = st.pin0;
      next_st.samp1 = st.pin1;
    end

    // level mode follows the sample; edge mode latches, set beats clear
    if (!ext0_trigger_select_in)
    begin
      next_st.flag0 = !st.samp0;
    end
    else
    begin
      if (vector_taken_in && st.req && st.src == SRC_EXT0)
      begin
        next_st.flag0 = 1'b0;
      end
      if (mc_tick && st.samp0 && !st.pin0)
      begin
        next_st.flag0 = 1'b1;
      end
    end
    if (!ext1_trigger_select_in)
    begin
      next_st.flag1 = !st.samp1;
    end
    else
    begin
      if (vector_taken_in && st.req && st.src == SRC_EXT1)
      begin
        next_st.flag1 = 1'b0;
      end
      if (mc_tick && st.samp1 && !st.pin1)
      begin
        next_st.flag1 = 1'b1;
      end
    end

    // active level stack; return pops the highest, restoring the previous level
    if (return_in)
    begin
      next_st.active[cur_lvl] = 1'b0;
    end
    if (vector_taken_in && st.req)
    begin
      next_st.active[st.lvl] = 1'b1;
      next_st.req = 1'b0;
    end
    else if (mc_tick)
    begin
      // one decision per machine cycle, held until taken or re-decided
      next_st.req = win_any && may_preempt && (power_mode_in == FLIC_RUN);
      next_st.src = win_src;
      next_st.lvl = win_lvl;
      next_st.vec = flic_vector(win_src);
    end

    // idle wakes on any pending source, power down only on the wake capable ones
    unique case (power_mode_in)
      FLIC_IDLE: next_st.wake = |pend;
      FLIC_PDWN: next_st.wake = |(pend & WAKE_MASK);
      default:   next_st.wake = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st <= '{mc_cnt: '0, sync0: 3'h7, sync1: 3'h7, pin0: 1'b1, pin1: 1'b1,
              samp0: 1'b1, samp1: 1'b1, flag0: 1'b0, flag1: 1'b0,
              active: '0, req: 1'b0, src: SRC_EXT0, lvl: 2'h0,
              vec: REG_RESET, wake: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign irq_request_out       = st.req;
  assign irq_vector_out        = st.vec;
  assign irq_source_out        = st.src;
  assign active_level_out      = cur_lvl;
  assign in_service_out        = |st.active[DEPTH-2:0];
  assign wake_out              = st.wake;
  assign ext0_request_flag_out = st.flag0;
  assign ext1_request_flag_out = st.flag1;

endmodule : flic_core

// >>> bench/flic_sva.sv
// checker: port-level assertions for the interrupt controller
`timescale 1ns/1ns
module flic_sva
  import flic_pkg::*;
(
  // clock and reset
  input wire logic                clk_sys_in,
  input wire logic                nrst_in,
  // inputs seen by the design
  input wire logic [7:0]          irq_enable_group_a_in,
  input wire logic                ext0_trigger_select_in,
  input wire logic                ext_irq_pin0_n_in,
  input wire logic                vector_taken_in,
  input wire logic                return_in,
  input wire flic_pkg::flic_pwr_e power_mode_in,
  // design outputs
  input wire logic                irq_request_out,
  input wire logic [VEC_W-1:0]    irq_vector_out,
  input wire logic [SRC_W-1:0]    irq_source_out,
  input wire logic [LVL_W-1:0]    active_level_out,
  input wire logic                in_service_out,
  input wire logic                ext0_request_flag_out
);
  localparam logic [7:0] VEC [NUM_SRC] = '{8'h03, 8'h2B, 8'h53, 8'h0B, 8'h33, 8'h5B, 8'h13,
                                           8'h3B, 8'h63, 8'h1B, 8'h43, 8'h23, 8'h73};
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  sequence taking;
    irq_request_out && vector_taken_in && !return_in;
  endsequence
  sequence pin_low_run;
    (!ext0_trigger_select_in && !ext_irq_pin0_n_in) [*8];
  endsequence
  chk_vec_match: assert property (irq_request_out |-> irq_vector_out == VEC[irq_source_out])
    else $error("vector does not match source");
  chk_global_gate: assert property ($rose(irq_request_out) |-> $past(irq_enable_group_a_in[7]))
    else $error("request while global allow low");
  chk_run_only: assert property ($rose(irq_request_out) |-> $past(power_mode_in) == FLIC_RUN)
    else $error("request outside run mode");
  chk_top_blocks: assert property ($rose(irq_request_out) |-> $past(active_level_out) != LVL_TOP)
    else $error("request during top level service");
  chk_take_drop: assert property (taking |=> !irq_request_out)
    else $error("request held after take");
  chk_take_push: assert property (taking |=> in_service_out)
    else $error("take did not mark service");
  chk_idle_zero: assert property (!in_service_out |-> active_level_out == 2'h0)
    else $error("level shown with nothing in service");
  chk_level_track: assert property (pin_low_run |-> ##[0:8] ext0_request_flag_out)
    else $error("level flag not following pin");
endmodule : flic_sva

bind flic_core flic_sva chk_u (.clk_sys_in, .nrst_in, .irq_enable_group_a_in,
  .ext0_trigger_select_in, .ext_irq_pin0_n_in, .vector_taken_in, .return_in, .power_mode_in,
  .irq_request_out, .irq_vector_out, .irq_source_out, .active_level_out, .in_service_out,
  .ext0_request_flag_out);

// >>> bench/flic_cpu_model.sv
// partner: core sequencer that accepts vectors and returns from service
`timescale 1ns/1ns
module flic_cpu_model
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  // controller side
  input  wire logic       irq_request_in,
  output logic            vector_taken_out,
  output logic            return_out,
  // bench control
  input  wire logic [3:0] slow_in,
  input  wire logic       ret_cmd_in,
  output logic [7:0]      n_take_out
);
  logic [3:0] wait_cnt;
  // a slow core lets the controller re-decide before the take lands
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      vector_taken_out <= 1'b0;
      return_out <= 1'b0;
      n_take_out <= 8'h00;
      wait_cnt <= 4'h0;
    end
    else
    begin
      return_out <= ret_cmd_in;
      vector_taken_out <= irq_request_in && !vector_taken_out && wait_cnt >= slow_in;
      n_take_out <= n_take_out + 8'((irq_request_in && !vector_taken_out && wait_cnt >= slow_in));
      wait_cnt <= (irq_request_in && !vector_taken_out) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : flic_cpu_model

// >>> bench/four_level_interrupt_controller_tb.sv
// testbench: sequences of source, priority and pin stimulus with expected vectors
`timescale 1ns/1ns
module four_level_interrupt_controller_tb;
  import flic_pkg::*;
  logic clk_sys_in = 0, nrst_in = 0, t0 = 0, p0 = 1, p1 = 1, ret_cmd = 0;
  logic [15:0] en = 0, pl = 0, ph = 0;
  logic [12:0] flg = 0;
  logic [3:0] slow = 0;
  flic_pwr_e pm = FLIC_RUN;
  logic req, insv, wake, f0, f1, tk, rt;
  logic [7:0] vec, ntk;
  logic [3:0] src;
  logic [1:0] lvl;
  int n_errors = 0, checks_done = 0, cyc = 0;
  int pos [13] = '{0, 5, 6, 1, 8, 12, 2, 9, 13, 3, 10, 4, 15};
  logic [7:0] vt [13] = '{8'h03, 8'h2B, 8'h53, 8'h0B, 8'h33, 8'h5B, 8'h13, 8'h3B, 8'h63,
                          8'h1B, 8'h43, 8'h23, 8'h73};
  flic_core dut_u (.clk_sys_in, .nrst_in, .irq_enable_group_a_in(en[7:0]),
    .irq_enable_group_b_in(en[15:8]), .prio_low_group_a_in(pl[7:0]),
    .prio_high_group_a_in(ph[7:0]), .prio_low_group_b_in(pl[15:8]),
    .prio_high_group_b_in(ph[15:8]), .ext0_trigger_select_in(t0), .ext1_trigger_select_in(1'b0),
    .ext_irq_pin0_n_in(p0), .ext_irq_pin1_n_in(p1), .brownout_flag_in(flg[1]),
    .watchdog_overflow_flag_in(flg[2]), .timer0_overflow_flag_in(flg[3]),
    .twowire_attention_flag_in(flg[4]), .converter_done_flag_in(flg[5]),
    .keypad_flag_in(flg[7]), .comparator1_flag_in(flg[8]), .timer1_overflow_flag_in(flg[9]),
    .comparator2_flag_in(flg[10]), .serial_flag_in(flg[11]), .bus_timeout_flag_in(flg[12]),
    .vector_taken_in(tk), .return_in(rt), .power_mode_in(pm), .irq_request_out(req),
    .irq_vector_out(vec), .irq_source_out(src), .active_level_out(lvl), .in_service_out(insv),
    .wake_out(wake), .ext0_request_flag_out(f0), .ext1_request_flag_out(f1));
  flic_cpu_model cpu_u (.clk_sys_in, .nrst_in, .irq_request_in(req), .vector_taken_out(tk),
    .return_out(rt), .slow_in(slow), .ret_cmd_in(ret_cmd), .n_take_out(ntk));
  initial
  begin
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic src_on(input int r, input logic on);
    if (r == 0) p0 <= !on;
    else if (r == 6) p1 <= !on;
    else flg[r] <= on;
  endtask : src_on
  // waits on the core's take and checks what was on offer at that edge
  task automatic serve(input int r);
    @(negedge clk_sys_in);
    for (int k = 0; k < 60 && tk !== 1'b1; k++) @(negedge clk_sys_in);
    chk({4'h0, src}, 8'(r));
    chk(vec, vt[r]);
  endtask : serve
  task automatic quiet(input int n);
    logic [7:0] n0;
    n0 = ntk;
    repeat (n) @(negedge clk_sys_in);
    chk(ntk, n0);
  endtask : quiet
  // the gap lets a released pin settle through the sync and sampling
  task automatic ret;
    repeat (14) @(posedge clk_sys_in);
    ret_cmd <= 1'b1;
    @(posedge clk_sys_in);
    ret_cmd <= 1'b0;
  endtask : ret
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(negedge clk_sys_in);
    chk({req, insv, wake, f0, f1, lvl}, 8'h00);
    for (int m = 0; m < 3; m++)
      for (int i = 0; i < 13; i++)
      begin
        @(posedge clk_sys_in);
        slow <= 4'(i);
        en <= (m == 0) ? (16'h0080 | (16'h1 << pos[i])) : 16'hFFFF;
        pl <= (m == 0) ? 16'h0 : (16'h1 << pos[i]);
        ph <= (m == 2) ? (16'h1 << pos[i]) : 16'h0;
        flg <= 13'h1FFF;
        p0 <= 1'b0;
        p1 <= 1'b0;
        serve(i);
        quiet(30);
        @(posedge clk_sys_in);
        en <= 16'h0080;
        ret;
      end
    en <= 16'hFF7F;
    quiet(30);
    @(posedge clk_sys_in);
    {en, pl, ph, slow} <= {16'hFFFF, 36'h0};
    for (int i = 0; i < 13; i++)
    begin
      serve(i);
      @(posedge clk_sys_in);
      src_on(i, 1'b0);
      ret;
    end
    // two flag sources raised together; a pin source would lag through the sync
    src_on(3, 1'b1);
    src_on(9, 1'b1);
    serve(3);
    @(posedge clk_sys_in);
    pl <= 16'h0008;
    serve(9);
    @(negedge clk_sys_in);
    chk(lvl, 8'h01);
    @(posedge clk_sys_in);
    src_on(3, 1'b0);
    src_on(9, 1'b0);
    ret;
    ret;
    // pin held high past one machine cycle, then low, so the edge is seen
    {t0, pl, en} <= {1'b1, 16'h0, 16'h0081};
    repeat (12) @(posedge clk_sys_in);
    p0 <= 1'b0;
    serve(0);
    @(negedge clk_sys_in);
    chk(f0, 8'h00);
    ret;
    quiet(30);
    @(posedge clk_sys_in);
    t0 <= 1'b0;
    serve(0);
    chk(f0, 8'h01);
    ret;
    serve(0);
    @(posedge clk_sys_in);
    p0 <= 1'b1;
    repeat (14) @(negedge clk_sys_in);
    chk(f0, 8'h00);
    ret;
    {pm, p0} <= {FLIC_IDLE, 1'b0};
    for (int k = 0; k < 30 && wake !== 1'b1; k++) @(negedge clk_sys_in);
    chk(wake, 8'h01);
    @(posedge clk_sys_in);
    {pm, p0, en, flg[3]} <= {FLIC_PDWN, 1'b1, 16'h0082, 1'b1};
    repeat (20) @(negedge clk_sys_in);
    chk(wake, 8'h00);
    @(posedge clk_sys_in);
    {en, flg[5]} <= {16'h1080, 1'b1};
    for (int k = 0; k < 30 && wake !== 1'b1; k++) @(negedge clk_sys_in);
    chk(wake, 8'h01);
    end_of_test;
  end
endmodule : four_level_interrupt_controller_tb
